// File: rtl/ctas_pkg.sv
// Notes on behaviour
// - The device answers only select codes whose low three bits match its three select pads.
// - The host writes a frame without CRC and the device appends both CRC bytes on the radio.
// - Frame bytes are written over I2C and radio transmission starts only after the stop.
// - After sending, the device waits for an answer and stores its decoded bytes in the frame.
// - While a radio exchange runs the device ignores all I2C traffic.
// - On the answer's end of frame the CRC is checked and the I2C side reconnects.
// - With no answer within the timeout set by parameter bits 6:5 the no-answer value is stored.
// - A write to the trigger register runs a whole sixteen-slot anti-collision pass on its own.
// - The pass sends one initiate command, then slot commands one to fifteen, waiting after each.
// - A slot whose answer decodes correctly stores the tag identifier in that slot's entry.
// - A slot with no answer or a bad answer stores an error code in that slot's entry.
// - A standard answer with a bad CRC leaves FFh in the frame register.
// - Reads of the trigger register return FFh until the host stops acknowledging.
package ctas_pkg;
  localparam int CLK_KHZ = 25000;
  localparam logic [3:0] DEVSEL_TYPE = 4'hA; // arbitrary value
  localparam logic [7:0] REG_PARAM = 8'h00;
  localparam logic [7:0] REG_FRAME = 8'h01;
  localparam logic [7:0] REG_TRIG = 8'h03;
  localparam logic [7:0] REG_LAST = 8'h06;
  localparam logic [7:0] PARAM_RESET = 8'h00;
  localparam int TIMEOUT_LSB = 5;
  localparam logic [5:0] FRAME_BYTES = 6'h24;
  localparam logic [5:0] FRAME_LAST = 6'h23;
  localparam logic [7:0] READ_FILL = 8'hFF;
  localparam logic [7:0] CRC_FAIL_CODE = 8'hFF;
  localparam logic [7:0] SLOT_ERR_CODE = 8'hFF;
  localparam logic [7:0] NO_ANSWER_LEN = 8'h00;
  localparam logic [7:0] SLOT_TOTAL = 8'h10;
  localparam logic [3:0] SLOT_LAST = 4'hF;
  localparam logic [7:0] INIT_CMD_B0 = 8'h06;
  localparam logic [7:0] INIT_CMD_B1 = 8'h04;
  localparam logic [3:0] SLOT_CMD_LOW = 4'h6;
  localparam logic [5:0] SLOT_ANSWER_LEN = 6'h03;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE = 16'hF0B8;
  localparam int TXQ_W = 9;
  // =====================================================
  // timing
  localparam int GUARD_NS = 75520;
  localparam logic [11:0] GUARD_CYC = 12'((GUARD_NS * CLK_KHZ / 1000 + 999) / 1000);
  localparam int TO0_US = 20;
  localparam int TO1_US = 40;
  localparam int TO2_US = 80;
  localparam int TO3_US = 160;
  localparam logic [11:0] TO0_CYC = 12'(TO0_US * CLK_KHZ / 1000);
  localparam logic [11:0] TO1_CYC = 12'(TO1_US * CLK_KHZ / 1000);
  localparam logic [11:0] TO2_CYC = 12'(TO2_US * CLK_KHZ / 1000);
  localparam logic [11:0] TO3_CYC = 12'(TO3_US * CLK_KHZ / 1000);

  // one byte through the reflected crc, lsb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte
endpackage : ctas_pkg

// File: rtl/ctas_buf2.sv
`timescale 1ns/100ps
`default_nettype none
module ctas_buf2 #(parameter int W = ctas_pkg::TXQ_W) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  logic [W-1:0] head_q, head_d, tail_q, tail_d;
  logic [1:0] cnt_q, cnt_d;
  logic valid_q, push, pop;

  assign in_ready_o = (cnt_q != 2'h2);
  assign out_valid_o = valid_q;
  assign out_data_o = head_q;

  // =====================================================
  // head always holds the oldest word so the output is a flop
  always_comb begin
    push = in_valid_i && in_ready_o;
    pop = valid_q && out_ready_i;
    head_d = head_q;
    tail_d = tail_q;
    if (pop) begin
      head_d = tail_q;
    end
    if (push) begin
      if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop)) begin
        head_d = in_data_i;
      end else begin
        tail_d = in_data_i;
      end
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      head_q <= '0;
      tail_q <= '0;
      cnt_q <= 2'h0;
      valid_q <= 1'b0;
    end else begin
      head_q <= head_d;
      tail_q <= tail_d;
      cnt_q <= cnt_d;
      valid_q <= (cnt_d != 2'h0);
    end
  end
endmodule : ctas_buf2
`default_nettype wire

// File: rtl/ctas_top.sv
`timescale 1ns/100ps
`default_nettype none
module ctas_top (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic select_pad_bit0_i,
  input wire logic select_pad_bit1_i,
  input wire logic select_pad_bit2_i,
  output logic [7:0] tx_data_o,
  output logic tx_last_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic rx_link_clk_i,
  input wire logic rx_frame_i,
  input wire logic rx_bit_i,
  output logic busy_o
);
  typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_TX, I_RACK, I_WAIT} ctas_i2c_t;
  typedef enum logic [2:0] {S_IDLE, S_TX, S_DRAIN, S_GUARD, S_WAIT, S_RX} ctas_seq_t;

  // =====================================================
  // pin synchronisers; stage one feeds stage two only
  logic [7:0] s1_q, s2_q, s3_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1_q <= 8'h03;
      s2_q <= 8'h03;
      s3_q <= 8'h03;
    end else begin
      s1_q <= {rx_bit_i, rx_frame_i, rx_link_clk_i, select_pad_bit2_i,
               select_pad_bit1_i, select_pad_bit0_i, sda_i, scl_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic sda_s, scl_rise, scl_fall, i2c_start, i2c_stop, lk_rise, fr_rise, fr_fall;
  logic [2:0] pads;
  assign sda_s = s2_q[1];
  assign pads = s2_q[4:2];
  assign scl_rise = s2_q[0] & ~s3_q[0];
  assign scl_fall = ~s2_q[0] & s3_q[0];
  // data edges while the clock stays high mark start and stop
  assign i2c_start = s2_q[0] & s3_q[0] & ~s2_q[1] & s3_q[1];
  assign i2c_stop = s2_q[0] & s3_q[0] & s2_q[1] & ~s3_q[1];
  assign lk_rise = s2_q[5] & ~s3_q[5];
  assign fr_rise = s2_q[6] & ~s3_q[6];
  assign fr_fall = ~s2_q[6] & s3_q[6];

  // =====================================================
  // frame register storage, one write port shared by both sides
  logic [7:0] frame_mem [36];
  logic mem_we, i_we, s_we;
  logic [5:0] mem_wa, i_wa, s_wa;
  logic [7:0] mem_wd, i_wd, s_wd;
  // the two sides never write together: the bus is deaf while radio runs
  always_comb begin
    mem_we = i_we | s_we;
    mem_wa = s_we ? s_wa : i_wa;
    mem_wd = s_we ? s_wd : i_wd;
  end
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      frame_mem[mem_wa] <= mem_wd;
    end
  end

  // =====================================================
  // i2c slave
  ctas_i2c_t i_st_q, i_st_d;
  ctas_seq_t seq_q, seq_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, param_q, param_d, rd_byte;
  logic [1:0] byte_no_q, byte_no_d;
  logic [5:0] idx_q, idx_d;
  logic rd_q, rd_d, oe_q, oe_d, wrote_q, wrote_d, trig_q, trig_d, ack, go_std, go_anti;

  // read source; the trigger register and holes read as fill
  always_comb begin
    if (ptr_q == ctas_pkg::REG_PARAM) begin
      rd_byte = param_q;
    end else if (ptr_q == ctas_pkg::REG_FRAME && idx_q < ctas_pkg::FRAME_BYTES) begin
      rd_byte = frame_mem[idx_q];
    end else begin
      rd_byte = ctas_pkg::READ_FILL;
    end
  end

  always_comb begin
    i_st_d = i_st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    byte_no_d = byte_no_q;
    rd_d = rd_q;
    ptr_d = ptr_q;
    idx_d = idx_q;
    oe_d = oe_q;
    wrote_d = wrote_q;
    trig_d = trig_q;
    param_d = param_q;
    i_we = 1'b0;
    i_wa = idx_q;
    i_wd = sh_q;
    ack = 1'b1;
    go_std = 1'b0;
    go_anti = 1'b0;
    if (seq_q != S_IDLE) begin
      i_st_d = I_IDLE;
      oe_d = 1'b0;
    end else if (i2c_start) begin
      i_st_d = I_RX;
      bit_d = 4'h0;
      byte_no_d = 2'h0;
      oe_d = 1'b0;
    end else if (i2c_stop) begin
      i_st_d = I_IDLE;
      oe_d = 1'b0;
      go_std = wrote_q;
      go_anti = trig_q;
      wrote_d = 1'b0;
      trig_d = 1'b0;
    end else begin
      case (i_st_q)
        I_RX: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_s};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            bit_d = 4'h0;
            if (byte_no_q == 2'h0) begin
              rd_d = sh_q[0];
              // a read naming a pointer past the map is refused at select
              ack = (sh_q[7:1] == {ctas_pkg::DEVSEL_TYPE, pads}) &&
                    !(sh_q[0] && ptr_q > ctas_pkg::REG_LAST);
            end else if (byte_no_q == 2'h1) begin
              ptr_d = sh_q;
              idx_d = 6'h00;
              ack = (sh_q <= ctas_pkg::REG_LAST);
            end else if (ptr_q == ctas_pkg::REG_PARAM) begin
              param_d = sh_q;
            end else if (ptr_q == ctas_pkg::REG_FRAME) begin
              // bytes past the end are acked and dropped
              i_we = (idx_q < ctas_pkg::FRAME_BYTES);
              wrote_d = 1'b1;
              if (idx_q < ctas_pkg::FRAME_BYTES) begin
                idx_d = idx_q + 6'h01;
              end
            end else if (ptr_q == ctas_pkg::REG_TRIG) begin
              trig_d = 1'b1;
            end
            if (byte_no_q != 2'h2) begin
              byte_no_d = byte_no_q + 2'h1;
            end
            i_st_d = ack ? I_ACK : I_WAIT;
            oe_d = ack;
          end
        end
        I_ACK: begin
          if (scl_fall) begin
            bit_d = 4'h0;
            if (rd_q) begin
              sh_d = rd_byte;
              oe_d = ~rd_byte[7];
              i_st_d = I_TX;
              if (ptr_q == ctas_pkg::REG_FRAME && idx_q < ctas_pkg::FRAME_BYTES) begin
                idx_d = idx_q + 6'h01;
              end
            end else begin
              oe_d = 1'b0;
              i_st_d = I_RX;
            end
          end
        end
        I_TX: begin
          if (scl_fall) begin
            bit_d = bit_q + 4'h1;
            sh_d = {sh_q[6:0], 1'b0};
            if (bit_q == 4'h7) begin
              oe_d = 1'b0;
              i_st_d = I_RACK;
            end else begin
              oe_d = ~sh_q[6];
            end
          end
        end
        I_RACK: begin
          // a master nack ends the read; until then each ack loads the next read byte
          if (scl_rise) begin
            i_st_d = sda_s ? I_WAIT : I_ACK;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      i_st_q <= I_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      byte_no_q <= 2'h0;
      rd_q <= 1'b0;
      ptr_q <= 8'h00;
      idx_q <= 6'h00;
      oe_q <= 1'b0;
      wrote_q <= 1'b0;
      trig_q <= 1'b0;
      param_q <= ctas_pkg::PARAM_RESET;
    end else begin
      i_st_q <= i_st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      byte_no_q <= byte_no_d;
      rd_q <= rd_d;
      ptr_q <= ptr_d;
      idx_q <= idx_d;
      oe_q <= oe_d;
      wrote_q <= wrote_d;
      trig_q <= trig_d;
      param_q <= param_d;
    end
  end
  assign sda_oe_o = oe_q;
  assign sda_o = 1'b0; // open drain: only ever pulls low

  // =====================================================
  // radio sequencer
  logic anti_q, anti_d, busy_q, push, push_last, buf_in_ready, fin, got, ok;
  logic [3:0] slot_q, slot_d;
  logic [5:0] k_q, k_d, len_q, len_d, rcnt_q, rcnt_d;
  logic [2:0] rbit_q, rbit_d;
  logic [7:0] push_data, tx_src, rsh_q, rsh_d, rid_q, rid_d;
  logic [15:0] crc_q, crc_d, rcrc_q, rcrc_d;
  logic [11:0] tmr_q, tmr_d, to_cyc;

  // answer timeout picked by the parameter register
  always_comb begin
    case (param_q[ctas_pkg::TIMEOUT_LSB +: 2])
      2'h0: to_cyc = ctas_pkg::TO0_CYC;
      2'h1: to_cyc = ctas_pkg::TO1_CYC;
      2'h2: to_cyc = ctas_pkg::TO2_CYC;
      default: to_cyc = ctas_pkg::TO3_CYC;
    endcase
  end

  // command bytes of the automatic pass, else host frame bytes
  always_comb begin
    if (!anti_q) begin
      tx_src = frame_mem[k_q];
    end else if (slot_q != 4'h0) begin
      tx_src = {slot_q, ctas_pkg::SLOT_CMD_LOW};
    end else begin
      tx_src = (k_q == 6'h00) ? ctas_pkg::INIT_CMD_B0 : ctas_pkg::INIT_CMD_B1;
    end
  end

  always_comb begin
    seq_d = seq_q;
    anti_d = anti_q;
    slot_d = slot_q;
    k_d = k_q;
    len_d = len_q;
    crc_d = crc_q;
    tmr_d = tmr_q;
    rcnt_d = rcnt_q;
    rbit_d = rbit_q;
    rsh_d = rsh_q;
    rcrc_d = rcrc_q;
    rid_d = rid_q;
    s_we = 1'b0;
    s_wa = 6'h00;
    s_wd = 8'h00;
    push = 1'b0;
    push_data = 8'h00;
    push_last = 1'b0;
    fin = 1'b0;
    got = 1'b0;
    ok = (rcrc_q == ctas_pkg::CRC_RESIDUE) && (rcnt_q >= 6'h02);
    case (seq_q)
      S_IDLE: begin
        k_d = 6'h00;
        crc_d = ctas_pkg::CRC_INIT;
        if (go_anti) begin
          anti_d = 1'b1;
          slot_d = 4'h0;
          len_d = 6'h02;
          seq_d = S_TX;
          s_we = 1'b1;
          s_wd = ctas_pkg::SLOT_TOTAL;
        end else if (go_std) begin
          anti_d = 1'b0;
          len_d = idx_q;
          seq_d = S_TX;
        end
      end
      S_TX: begin
        push = 1'b1;
        if (k_q < len_q) begin
          push_data = tx_src;
        end else if (k_q == len_q) begin
          push_data = ~crc_q[7:0];
        end else begin
          push_data = ~crc_q[15:8];
          push_last = 1'b1;
        end
        if (buf_in_ready) begin
          k_d = k_q + 6'h01;
          if (k_q < len_q) begin
            crc_d = ctas_pkg::crc_byte(crc_q, push_data);
          end
          if (push_last) begin
            seq_d = S_DRAIN;
          end
        end
      end
      S_DRAIN: begin
        if (!tx_valid_o) begin
          seq_d = S_GUARD;
          tmr_d = ctas_pkg::GUARD_CYC;
        end
      end
      S_GUARD: begin
        // a start of frame inside the guard is not an answer
        if (tmr_q == 12'h000) begin
          seq_d = S_WAIT;
          tmr_d = to_cyc;
        end else begin
          tmr_d = tmr_q - 12'h001;
        end
      end
      S_WAIT: begin
        if (fr_rise) begin
          seq_d = S_RX;
          rcnt_d = 6'h00;
          rbit_d = 3'h0;
          rcrc_d = ctas_pkg::CRC_INIT;
        end else if (tmr_q == 12'h000) begin
          fin = 1'b1;
        end else begin
          tmr_d = tmr_q - 12'h001;
        end
      end
      S_RX: begin
        if (lk_rise && s2_q[6]) begin
          rsh_d = {s2_q[7], rsh_q[7:1]};
          rbit_d = rbit_q + 3'h1;
          if (rbit_q == 3'h7) begin
            rcrc_d = ctas_pkg::crc_byte(rcrc_q, rsh_d);
            if (!anti_q && rcnt_q < ctas_pkg::FRAME_LAST) begin
              s_we = 1'b1;
              s_wa = rcnt_q + 6'h01;
              s_wd = rsh_d;
            end
            if (rcnt_q == 6'h00) begin
              rid_d = rsh_d;
            end
            if (rcnt_q != 6'h3F) begin
              rcnt_d = rcnt_q + 6'h01;
            end
          end
        end
        if (fr_fall) begin
          fin = 1'b1;
          got = 1'b1;
        end
      end
      default: seq_d = S_IDLE;
    endcase
    // close one answer window: store result, then next slot or back to the bus
    if (fin) begin
      s_we = 1'b1;
      if (anti_q) begin
        s_wa = {2'b00, slot_q} + 6'h01;
        s_wd = (got && ok && rcnt_q == ctas_pkg::SLOT_ANSWER_LEN) ? rid_q :
               ctas_pkg::SLOT_ERR_CODE;
        if (slot_q != ctas_pkg::SLOT_LAST) begin
          slot_d = slot_q + 4'h1;
          k_d = 6'h00;
          len_d = 6'h01;
          crc_d = ctas_pkg::CRC_INIT;
          seq_d = S_TX;
        end else begin
          seq_d = S_IDLE;
        end
      end else begin
        s_wa = 6'h00;
        s_wd = !got ? ctas_pkg::NO_ANSWER_LEN :
               ok ? {2'b00, rcnt_q - 6'h02} : ctas_pkg::CRC_FAIL_CODE;
        seq_d = S_IDLE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      seq_q <= S_IDLE;
      anti_q <= 1'b0;
      slot_q <= 4'h0;
      k_q <= 6'h00;
      len_q <= 6'h00;
      crc_q <= ctas_pkg::CRC_INIT;
      tmr_q <= 12'h000;
      rcnt_q <= 6'h00;
      rbit_q <= 3'h0;
      rsh_q <= 8'h00;
      rcrc_q <= ctas_pkg::CRC_INIT;
      rid_q <= 8'h00;
      busy_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      anti_q <= anti_d;
      slot_q <= slot_d;
      k_q <= k_d;
      len_q <= len_d;
      crc_q <= crc_d;
      tmr_q <= tmr_d;
      rcnt_q <= rcnt_d;
      rbit_q <= rbit_d;
      rsh_q <= rsh_d;
      rcrc_q <= rcrc_d;
      rid_q <= rid_d;
      busy_q <= (seq_d != S_IDLE);
    end
  end
  assign busy_o = busy_q;

  // two-entry buffer so a stalled modulator loses no byte
  logic [8:0] buf_out;
  ctas_buf2 u_buf (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(push),
    .in_ready_o(buf_in_ready),
    .in_data_i({push_last, push_data}),
    .out_valid_o(tx_valid_o),
    .out_ready_i(tx_ready_i),
    .out_data_o(buf_out)
  );
  assign tx_data_o = buf_out[7:0];
  assign tx_last_o = buf_out[8];

  // =====================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic bus_quiet;
  assign bus_quiet = (seq_q == S_IDLE) && !i2c_start && !i2c_stop;
  sequence stop_trig_s; seq_q == S_IDLE && i2c_stop && trig_q; endsequence
  sequence guard_hold_s; (seq_q == S_GUARD)[*8]; endsequence

  devsel_foreign_a: assert property (bus_quiet && i_st_q == I_RX && scl_fall &&
    bit_q == 4'h8 && byte_no_q == 2'h0 && sh_q[7:1] != {ctas_pkg::DEVSEL_TYPE, pads}
    |=> i_st_q == I_WAIT && !sda_oe_o) else $error("foreign select acknowledged");
  frame_launch_a: assert property (seq_q == S_IDLE && i2c_stop && wrote_q && !trig_q
    |=> seq_q == S_TX && !anti_q) else $error("frame not sent after stop");
  bus_deaf_a: assert property (seq_q != S_IDLE |=> !sda_oe_o)
    else $error("bus driven during exchange");
  anti_start_a: assert property (stop_trig_s |=> anti_q && seq_q == S_TX && slot_q == 4'h0)
    else $error("anti-collision pass not started");
  guard_time_a: assert property (seq_q == S_DRAIN && !tx_valid_o |=> guard_hold_s)
    else $error("answer guard too short");
  no_answer_a: assert property (seq_q == S_WAIT && !fr_rise && tmr_q == 12'h000 && !anti_q
    |=> seq_q == S_IDLE && frame_mem[0] == ctas_pkg::NO_ANSWER_LEN)
    else $error("no-answer value missing");
  crc_fail_a: assert property (seq_q == S_RX && fr_fall && !anti_q && !ok
    |=> frame_mem[0] == ctas_pkg::CRC_FAIL_CODE) else $error("bad crc not flagged");
  slot_step_a: assert property (fin && anti_q && slot_q != ctas_pkg::SLOT_LAST
    |=> seq_q == S_TX && slot_q == $past(slot_q) + 4'h1) else $error("slot order broken");
  slot_cmd_a: assert property (seq_q == S_TX && anti_q && slot_q != 4'h0 && k_q == 6'h00
    && buf_in_ready |=> crc_q == ctas_pkg::crc_byte(ctas_pkg::CRC_INIT,
    {$past(slot_q), ctas_pkg::SLOT_CMD_LOW})) else $error("slot command wrong");
  trig_read_a: assert property (bus_quiet && i_st_q == I_ACK && scl_fall && rd_q &&
    ptr_q == ctas_pkg::REG_TRIG |=> sh_q == ctas_pkg::READ_FILL && i_st_q == I_TX)
    else $error("trigger read not fill");
endmodule : ctas_top
`default_nettype wire

// File: tb/ctas_card.sv
`timescale 1ns/100ps
`default_nettype none
// =====
// card side
module ctas_card (
  input wire logic clk_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_last_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic rx_link_clk_o,
  output logic rx_frame_o,
  output logic rx_bit_o
);
  logic [8:0] got_q[$];
  logic [7:0] ans_q[$];
  int lens_q[$];
  bit slow = 1;
  int n;
  event req_e;
  // stall every other cycle when slow, so the buffer must hold words
  initial begin
    tx_ready_o = 1'b0;
    forever @(negedge clk_i) tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
  end
  // capture request bytes; the last one starts the answer
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got_q.push_back({tx_last_i, tx_data_i});
      if (tx_last_i) ->req_e;
    end
  end
  // answer after the guard but inside the shortest timeout; length 0 stays silent
  initial begin
    {rx_link_clk_o, rx_frame_o, rx_bit_o} = 3'h0;
    forever begin
      @(req_e);
      n = lens_q.size() ? lens_q.pop_front() : 0;
      repeat (2000) @(negedge clk_i);
      if (n > 0) begin
        rx_frame_o = 1'b1;
        repeat (n) send(ans_q.pop_front());
        #160 rx_frame_o = 1'b0;
        rx_bit_o = ~rx_bit_o; // a released line keeps no stale bit
      end
    end
  end
  // one byte, lsb first; the link clock stands still outside frames
  task automatic send(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      rx_bit_o = d[i];
      #160 rx_link_clk_o = 1'b1;
      #160 rx_link_clk_o = 1'b0;
    end
  endtask : send
endmodule : ctas_card
`default_nettype wire

// File: tb/ctas_bench.sv
`timescale 1ns/100ps
`default_nettype none
module ctas_bench;
  logic clk_i = 0;
  logic sys_rst_i = 1;
  logic scl = 1;
  logic sda = 1;
  logic [2:0] pads = 3'h0;
  logic sda_w, sda_oe, sda_dv, busy, tx_last, tx_valid, tx_ready, lclk, lframe, lbit, ack;
  logic [7:0] tx_data, b;
  logic [7:0] q[$], a[$], rq[$], id[16];
  logic [8:0] e[$];
  int mismatches, num_checks;
  int seed = 51;
  // open-drain data line with pull-up; the device only wins when it drives a low
  assign sda_w = sda & (~sda_oe | sda_dv);
  ctas_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_dv), .sda_oe_o(sda_oe), .select_pad_bit0_i(pads[0]),
    .select_pad_bit1_i(pads[1]),
    .select_pad_bit2_i(pads[2]), .tx_data_o(tx_data), .tx_last_o(tx_last),
    .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .rx_link_clk_i(lclk), .rx_frame_i(lframe),
    .rx_bit_i(lbit), .busy_o(busy));
  ctas_card i_card (.clk_i(clk_i), .tx_data_i(tx_data), .tx_last_i(tx_last),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_link_clk_o(lclk), .rx_frame_o(lframe),
    .rx_bit_o(lbit));
  // =====
  // 25 MHz clock
  initial forever #20 clk_i = ~clk_i;
  // append the complemented crc, low byte first
  function automatic void add_crc(ref logic [7:0] d[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (d[k]) begin
      c = c ^ {8'h00, d[k]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    d.push_back(~c[7:0]);
    d.push_back(~c[15:8]);
  endfunction : add_crc
  // expected request: body, crc, last flag on the final byte
  function automatic void req(input logic [7:0] d[$]);
    add_crc(d);
    foreach (d[k]) e.push_back({k == d.size() - 1, d[k]});
  endfunction : req
  task automatic hw();
    repeat (10) @(negedge clk_i);
  endtask : hw
  task automatic chk(input string nm, input logic [8:0] x, input logic [8:0] g);
    num_checks++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  // =====
  // two-wire host; sda moves only while scl is low, except for the start and stop edges
  task automatic sbit(input logic v);
    sda = v;
    hw();
    scl = 1;
    hw();
    b = {b[6:0], sda_w};
    scl = 0;
    hw();
  endtask : sbit
  task automatic start();
    sda = 1;
    hw();
    scl = 1;
    hw();
    sda = 0;
    hw();
    scl = 0;
    hw();
  endtask : start
  task automatic stop();
    sda = 0;
    hw();
    scl = 1;
    hw();
    sda = 1;
    hw();
  endtask : stop
  task automatic wbyte(input logic [7:0] x);
    for (int i = 7; i >= 0; i--) sbit(x[i]);
    sbit(1'b1);
    ack = ~b[0];
  endtask : wbyte
  task automatic sel(input logic r, input logic [2:0] p);
    start();
    wbyte({ctas_pkg::DEVSEL_TYPE, p, r});
  endtask : sel
  task automatic wr(input logic [7:0] ra);
    sel(0, pads);
    if (ack) wbyte(ra);
    foreach (q[k]) if (ack) wbyte(q[k]);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] ra, input int n);
    sel(0, pads);
    wbyte(ra);
    sel(1, pads);
    rq = {};
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 8; i++) sbit(1'b1);
      rq.push_back(b);
      sbit(k == n - 1);
    end
    stop();
  endtask : rd
  task automatic idle();
    int t = 0;
    while (busy !== 1'b0 && t < 60000) begin
      @(negedge clk_i);
      t++;
    end
    chk("idle", 0, busy);
    chk("tx count", 9'(e.size()), 9'(i_card.got_q.size()));
    foreach (e[k]) chk("tx byte", e[k], i_card.got_q[k]);
    i_card.got_q = {};
  endtask : idle
  // one exchange: load the card's answer, send a random request, read the frame back
  task automatic run(input logic [7:0] ans[$], input logic [7:0] x0);
    i_card.lens_q.push_back(ans.size());
    foreach (ans[k]) i_card.ans_q.push_back(ans[k]);
    q = {8'($random(seed)), 8'($random(seed)), 8'($random(seed))};
    e = {};
    req(q);
    wr(ctas_pkg::REG_FRAME);
    chk("frame ack", 1, ack);
    chk("busy", 1, busy);
    sel(0, pads);
    stop();
    chk("deaf ack", 0, ack);
    // the longest timeout keeps a silent exchange busy past where the shortest would end
    if (ans.size() == 0) begin
      repeat (3000) @(negedge clk_i);
      chk("timeout span", 1, busy);
    end
    idle();
    rd(ctas_pkg::REG_FRAME, ans.size() + 1);
    chk("frame head", x0, rq[0]);
    if (x0 != 8'hFF) foreach (ans[k]) chk("frame byte", ans[k], rq[k + 1]);
  endtask : run
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // watchdog, well past the expected run length
  initial begin
    repeat (100000) @(posedge clk_i);
    mismatches++;
    close_out();
  end
  // =====
  // main sequence
  initial begin
    repeat (12) @(negedge clk_i);
    sys_rst_i = 0;
    pads = 3'($random(seed));
    hw();
    sel(0, pads ^ 3'h5);
    stop();
    chk("other select", 0, ack);
    q = {};
    wr(8'h07);
    chk("unmapped ack", 0, ack);
    q = {8'h00};
    wr(ctas_pkg::REG_PARAM);
    chk("param ack", 1, ack);
    a = {8'($random(seed)), 8'($random(seed)), 8'($random(seed)), 8'($random(seed))};
    add_crc(a);
    run(a, 8'h04);
    a = {8'($random(seed)), 8'($random(seed)), 8'($random(seed))};
    add_crc(a);
    a[4] = ~a[4];
    run(a, 8'hFF);
    q = {8'h60};
    wr(ctas_pkg::REG_PARAM);
    rd(ctas_pkg::REG_PARAM, 1);
    chk("param read", 8'h60, rq[0]);
    a = {};
    run(a, 8'h00);
    q = {8'h00};
    wr(ctas_pkg::REG_PARAM);
    rd(ctas_pkg::REG_TRIG, 3);
    foreach (rq[k]) chk("trigger read", 8'hFF, rq[k]);
    i_card.slow = 0;
    e = {};
    for (int s = 0; s < 16; s++) begin
      id[s] = 8'($random(seed));
      if (s == 0) req({8'h06, 8'h04});
      else req({8'(s * 16 + 6)});
      a = {id[s]};
      add_crc(a);
      if (s == 5) a[2] = ~a[2];
      i_card.lens_q.push_back((s % 3 == 0) ? 0 : 3);
      if (s % 3 != 0) foreach (a[k]) i_card.ans_q.push_back(a[k]);
    end
    q = {8'($random(seed))};
    wr(ctas_pkg::REG_TRIG);
    chk("trigger ack", 1, ack);
    idle();
    rd(ctas_pkg::REG_FRAME, 17);
    chk("slot count", 8'h10, rq[0]);
    for (int s = 0; s < 16; s++) begin
      chk("slot", (s % 3 == 0 || s == 5) ? 8'hFF : id[s], rq[s + 1]);
    end
    close_out();
  end
endmodule : ctas_bench
`default_nettype wire
